/* File: design/timing_reference_selector.sv */
// Chosen here: the AXI4-Lite interface to the registers and the register addresses.
module timing_reference_selector import tref_pkg::*; #(
	parameter int LOS_CYCLES = LOS_CYC,
	parameter int CLEAR_CYCLES = CLEAR_CYC,
	parameter int RECOVER_CYCLES = RECOVER_CYC
) (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic ARST_N,
	// AXI4-Lite write
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [7:0] AWADDR,
	input wire logic WVALID,
	output logic WREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	output logic BVALID,
	input wire logic BREADY,
	output logic [1:0] BRESP,
	// AXI4-Lite read
	input wire logic ARVALID,
	output logic ARREADY,
	input wire logic [7:0] ARADDR,
	output logic RVALID,
	input wire logic RREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	// Reference inputs
	input wire logic [NREF-1:0] REF_PULSE,
	input wire logic [NREF-1:0] REF_CARRIER_FAIL,
	input wire logic [NREF-1:0] FRAMING_LOST_EVENT,
	input wire logic [NREF-1:0] REF_FRAME_ERR,
	input wire logic [NREF-1:0] REF_BER_MINOR,
	input wire logic [NREF-1:0] REF_BER_MAJOR,
	input wire logic [NREF-1:0] REF_SAMPLE_VALID,
	input wire logic [NREF*PHW-1:0] REF_SAMPLE,
	// Locking loop observations
	input wire logic FREQ_OFFSET_VALID,
	input wire logic signed [15:0] FREQ_OFFSET,
	input wire logic signed [15:0] LOOP_CTRL,
	input wire logic signed [15:0] LOOP_PHASE,
	input wire logic signed [15:0] OUT_FREQ_ERR,
	// Duplicate synchronizer
	input wire logic SELF_FAULT,
	input wire logic MATE_IN_SERVICE,
	input wire logic MATE_REF_GOOD,
	// Selection and loop feed
	output logic [IDXW-1:0] ACTIVE_REF,
	output logic HOLDOVER,
	output logic LOOP_SAMPLE_VALID,
	output logic signed [PHW-1:0] LOOP_SAMPLE,
	// Alarms and protection
	output logic FREQ_OFFSET_ALARM,
	output logic CONTROL_RANGE_LIMIT_ALARM,
	output logic PHASE_ALIGN_ALARM,
	output logic FREQ_ACCURACY_ALARM,
	output logic SYNC_ACTIVE,
	output logic SYNC_OUT_OF_SERVICE
);
	logic aw_ff, nxt_aw, w_ff, nxt_w, bv_ff, nxt_bv, awr_ff, nxt_awr;
	logic wr_ff, nxt_wr, rv_ff, nxt_rv, arr_ff, nxt_arr;
	logic [7:0] awa_ff, nxt_awa;
	logic [31:0] wd_ff, nxt_wd, rd_ff, nxt_rd;
	logic [3:0] ws_ff, nxt_ws;
	logic [1:0] br_ff, nxt_br, rr_ff, nxt_rr;
	logic do_wr;
	logic [31:0] ctrl_ff, nxt_ctrl, framed_ff, nxt_framed, serv_ff, nxt_serv;
	logic [31:0] prio_ff, nxt_prio, step_ff, nxt_step, fof_ff, nxt_fof;
	logic [NREF-1:0] loss, jit, clean, elig, step_vec;
	sel_state_t st_ff, nxt_st;
	logic [31:0] rc_ff, nxt_rc;
	logic [IDXW-1:0] act_ff, nxt_act, best_idx;
	logic best_ok;
	logic [PRIOW+1:0] best_key, key;
	logic hold_ff, nxt_hold;
	logic signed [PHW-1:0] raw, last_ff, nxt_last, out_ff, nxt_out;
	logic signed [PHW:0] delta;
	logic have_ff, nxt_have, lsv_ff, nxt_lsv, step_now, raw_v;
	logic fa_ff, nxt_fa, eor_ff, nxt_eor, pa_ff, nxt_pa, acc_ff, nxt_acc;
	logic sa_ff, nxt_sa, oos_ff, nxt_oos;
	logic [15:0] abs_off, abs_ctl, abs_ph, abs_out;

	// Write merge under byte strobes
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] d, input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (s[b])
				r[b*8 +: 8] = d[b*8 +: 8];
		end
		return r;
	endfunction

	function automatic logic [15:0] mag(input logic signed [15:0] v);
		return v[15] ? 16'(-v) : 16'(v);
	endfunction

	// Per-reference health monitors
	genvar gi;
	generate
		for (gi = 0; gi < NREF; gi++) begin : g_ref
			ref_health_monitor #(
				.LOS_CYCLES(LOS_CYCLES),
				.CLEAR_CYCLES(CLEAR_CYCLES)
			) u_mon (
				.clk(SYS_CLK),
				.arst_n(ARST_N),
				.pulse(REF_PULSE[gi]),
				.framed(framed_ff[gi]),
				.carrier_fail(REF_CARRIER_FAIL[gi]),
				.framing_lost_event(FRAMING_LOST_EVENT[gi]),
				.frame_err(REF_FRAME_ERR[gi]),
				.sample_valid(REF_SAMPLE_VALID[gi]),
				.sample(REF_SAMPLE[gi*PHW +: PHW]),
				.step(step_vec[gi]),
				.reference_loss_alarm(loss[gi]),
				.jitter_alarm(jit[gi]),
				.sample_clean(clean[gi])
			);
			// Only usable, in-service references compete
			assign elig[gi] = serv_ff[gi] & ~loss[gi] & ~jit[gi] & ~fof_ff[gi];
			assign step_vec[gi] = step_now && act_ff == IDXW'(gi) && !hold_ff;
		end
	endgenerate

	// Bus handshake and register writes
	always_comb begin
		nxt_aw = aw_ff;
		nxt_awa = awa_ff;
		nxt_w = w_ff;
		nxt_wd = wd_ff;
		nxt_ws = ws_ff;
		nxt_bv = bv_ff;
		nxt_br = br_ff;
		if (AWVALID && awr_ff) begin
			nxt_aw = 1'b1;
			nxt_awa = AWADDR;
		end
		if (WVALID && wr_ff) begin
			nxt_w = 1'b1;
			nxt_wd = WDATA;
			nxt_ws = WSTRB;
		end
		if (bv_ff && BREADY)
			nxt_bv = 1'b0;
		do_wr = aw_ff && w_ff && !bv_ff;
		nxt_ctrl = ctrl_ff;
		nxt_framed = framed_ff;
		nxt_serv = serv_ff;
		nxt_prio = prio_ff;
		nxt_step = step_ff;
		nxt_fof = fof_ff;
		if (do_wr) begin
			nxt_aw = 1'b0;
			nxt_w = 1'b0;
			nxt_bv = 1'b1;
			nxt_br = RESP_OKAY;
			case (awa_ff)
				ADDR_CTRL: nxt_ctrl = merge(ctrl_ff, wd_ff, ws_ff) & 32'h1;
				ADDR_FRAMED: nxt_framed = merge(framed_ff, wd_ff, ws_ff) & 32'hff;
				ADDR_SERVICE: nxt_serv = merge(serv_ff, wd_ff, ws_ff) & 32'hff;
				ADDR_PRIO: nxt_prio = merge(prio_ff, wd_ff, ws_ff) & 32'hffffff;
				ADDR_STEP: nxt_step = merge(step_ff, wd_ff, ws_ff) & 32'hffff;
				ADDR_FOFAIL: nxt_fof = fof_ff & ~(wd_ff & {24'h0, {8{ws_ff[0]}}});
				ADDR_STATUS, ADDR_REFSTAT: nxt_br = RESP_OKAY;
				default: nxt_br = RESP_SLVERR;
			endcase
		end
		// Offset failure on the active reference, set wins over clear
		if (FREQ_OFFSET_VALID && st_ff == ST_LOCKED
			&& mag(FREQ_OFFSET) > 16'(FREQ_LIMIT))
			nxt_fof[act_ff] = 1'b1;
		nxt_awr = !nxt_aw && !nxt_bv;
		nxt_wr = !nxt_w && !nxt_bv;
	end

	// Read channel
	always_comb begin
		nxt_rv = rv_ff;
		nxt_rd = rd_ff;
		nxt_rr = rr_ff;
		if (rv_ff && RREADY)
			nxt_rv = 1'b0;
		if (ARVALID && arr_ff) begin
			nxt_rv = 1'b1;
			nxt_rr = RESP_OKAY;
			case (ARADDR)
				ADDR_CTRL: nxt_rd = ctrl_ff;
				ADDR_FRAMED: nxt_rd = framed_ff;
				ADDR_SERVICE: nxt_rd = serv_ff;
				ADDR_PRIO: nxt_rd = prio_ff;
				ADDR_STEP: nxt_rd = step_ff;
				ADDR_FOFAIL: nxt_rd = fof_ff;
				ADDR_STATUS: nxt_rd = {16'h0, elig, acc_ff, pa_ff, eor_ff,
					sa_ff, hold_ff, act_ff};
				ADDR_REFSTAT: nxt_rd = {16'h0, jit, loss};
				default: begin
					nxt_rd = 32'h0;
					nxt_rr = RESP_SLVERR;
				end
			endcase
		end
		nxt_arr = !nxt_rv;
	end

	// Best reference: error-rate class first, then priority
	always_comb begin
		best_ok = 1'b0;
		best_idx = '0;
		best_key = '0;
		for (int i = 0; i < NREF; i++) begin
			key = {REF_BER_MAJOR[i] ? 2'h0 : (REF_BER_MINOR[i] ? 2'h1 : 2'h2),
				prio_ff[i*PRIOW +: PRIOW]};
			if (elig[i] && (!best_ok || key > best_key)) begin
				best_ok = 1'b1;
				best_idx = IDXW'(i);
				best_key = key;
			end
		end
	end

	// Holdover and selection sequence
	always_comb begin
		nxt_st = st_ff;
		nxt_rc = rc_ff;
		nxt_act = act_ff;
		case (st_ff)
			ST_HOLD: begin
				nxt_rc = 32'h0;
				if (best_ok)
					nxt_st = ST_RECOVER;
			end
			ST_RECOVER: begin
				nxt_rc = rc_ff + 32'h1;
				if (!best_ok)
					nxt_st = ST_HOLD;
				else if (rc_ff >= 32'(RECOVER_CYCLES - 1)) begin
					nxt_st = ST_LOCKED;
					nxt_act = best_idx;
				end
			end
			ST_LOCKED: begin
				if (!best_ok)
					nxt_st = ST_HOLD;
				else
					nxt_act = best_idx;
			end
			default: nxt_st = ST_MASTER;
		endcase
		if (ctrl_ff[CTRL_MASTER_BIT])
			nxt_st = ST_MASTER;
		else if (st_ff == ST_MASTER)
			nxt_st = ST_HOLD;
		nxt_hold = nxt_st != ST_LOCKED;
	end

	// Sample screening and phase build-out
	always_comb begin
		raw = REF_SAMPLE[act_ff*PHW +: PHW];
		raw_v = REF_SAMPLE_VALID[act_ff] && !hold_ff;
		delta = 17'(raw) - 17'(last_ff);
		step_now = raw_v && have_ff
			&& (delta[PHW] ? 17'(-delta) : delta) > 17'(step_ff[15:0]);
		nxt_last = raw_v ? raw : last_ff;
		nxt_have = raw_v ? 1'b1 : have_ff;
		nxt_out = out_ff;
		nxt_lsv = 1'b0;
		// Only deltas pass, so a switch leaves no phase jump
		if (raw_v && have_ff && !step_now && clean[act_ff]) begin
			nxt_out = PHW'(out_ff + delta);
			nxt_lsv = 1'b1;
		end
		if (nxt_act != act_ff || hold_ff)
			nxt_have = 1'b0;
	end

	// Loop alarms and duplicate protection
	always_comb begin
		abs_off = mag(FREQ_OFFSET);
		abs_ctl = mag(LOOP_CTRL);
		abs_ph = mag(LOOP_PHASE);
		abs_out = mag(OUT_FREQ_ERR);
		nxt_fa = |fof_ff;
		nxt_eor = !hold_ff && abs_ctl > 16'(EOR_LIMIT);
		nxt_pa = !hold_ff && abs_ph > 16'(PA_LIMIT);
		nxt_acc = st_ff == ST_MASTER && abs_out >= 16'(ACCURACY_LIMIT);
		nxt_sa = sa_ff;
		nxt_oos = oos_ff;
		if (sa_ff) begin
			if (SELF_FAULT && MATE_IN_SERVICE) begin
				nxt_sa = 1'b0;
				nxt_oos = 1'b1;
			end else if (st_ff == ST_HOLD && MATE_IN_SERVICE && MATE_REF_GOOD)
				nxt_sa = 1'b0;
		end else begin
			nxt_oos = SELF_FAULT;
			if (!SELF_FAULT && !MATE_IN_SERVICE)
				nxt_sa = 1'b1;
		end
	end

	// All registers
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			aw_ff <= 1'b0;
			w_ff <= 1'b0;
			bv_ff <= 1'b0;
			awr_ff <= 1'b0;
			wr_ff <= 1'b0;
			rv_ff <= 1'b0;
			arr_ff <= 1'b0;
			awa_ff <= 8'h0;
			wd_ff <= 32'h0;
			ws_ff <= 4'h0;
			rd_ff <= 32'h0;
			br_ff <= RESP_OKAY;
			rr_ff <= RESP_OKAY;
			ctrl_ff <= 32'h0;
			framed_ff <= 32'h0;
			serv_ff <= 32'h0;
			prio_ff <= 32'h0;
			step_ff <= {16'h0, STEP_RST};
			fof_ff <= 32'h0;
			st_ff <= ST_HOLD;
			rc_ff <= 32'h0;
			act_ff <= '0;
			hold_ff <= 1'b1;
			last_ff <= '0;
			out_ff <= '0;
			have_ff <= 1'b0;
			lsv_ff <= 1'b0;
			fa_ff <= 1'b0;
			eor_ff <= 1'b0;
			pa_ff <= 1'b0;
			acc_ff <= 1'b0;
			sa_ff <= 1'b1;
			oos_ff <= 1'b0;
		end else begin
			aw_ff <= nxt_aw;
			w_ff <= nxt_w;
			bv_ff <= nxt_bv;
			awr_ff <= nxt_awr;
			wr_ff <= nxt_wr;
			rv_ff <= nxt_rv;
			arr_ff <= nxt_arr;
			awa_ff <= nxt_awa;
			wd_ff <= nxt_wd;
			ws_ff <= nxt_ws;
			rd_ff <= nxt_rd;
			br_ff <= nxt_br;
			rr_ff <= nxt_rr;
			ctrl_ff <= nxt_ctrl;
			framed_ff <= nxt_framed;
			serv_ff <= nxt_serv;
			prio_ff <= nxt_prio;
			step_ff <= nxt_step;
			fof_ff <= nxt_fof;
			st_ff <= nxt_st;
			rc_ff <= nxt_rc;
			act_ff <= nxt_act;
			hold_ff <= nxt_hold;
			last_ff <= nxt_last;
			out_ff <= nxt_out;
			have_ff <= nxt_have;
			lsv_ff <= nxt_lsv;
			fa_ff <= nxt_fa;
			eor_ff <= nxt_eor;
			pa_ff <= nxt_pa;
			acc_ff <= nxt_acc;
			sa_ff <= nxt_sa;
			oos_ff <= nxt_oos;
		end
	end

	// Outputs straight from registers
	assign AWREADY = awr_ff;
	assign WREADY = wr_ff;
	assign BVALID = bv_ff;
	assign BRESP = br_ff;
	assign ARREADY = arr_ff;
	assign RVALID = rv_ff;
	assign RDATA = rd_ff;
	assign RRESP = rr_ff;
	assign ACTIVE_REF = act_ff;
	assign HOLDOVER = hold_ff;
	assign LOOP_SAMPLE_VALID = lsv_ff;
	assign LOOP_SAMPLE = out_ff;
	assign FREQ_OFFSET_ALARM = fa_ff;
	assign CONTROL_RANGE_LIMIT_ALARM = eor_ff;
	assign PHASE_ALIGN_ALARM = pa_ff;
	assign FREQ_ACCURACY_ALARM = acc_ff;
	assign SYNC_ACTIVE = sa_ff;
	assign SYNC_OUT_OF_SERVICE = oos_ff;
endmodule // timing_reference_selector

/* File: design/tref_pkg.sv */
// What this block does
// - Phase step, frequency checks on active reference only
// - Drop active samples whose step exceeds threshold
// - Detected steps feed the jitter measurement
// - Active offset over 9 ppm: out of service, alarm
// - Up to eight references, exactly one active
// - Loss, jitter, offset or out-of-service: not eligible
// - Rank clean, then minor, then major error rate
// - Same class: highest provisioned priority wins
// - No usable reference: holdover plus recovery hysteresis
// - Reference switches cause no output phase jump
// - Control value beyond 3/4 range raises alarm when locked
// - Phase offset over 125 us raises alarm when locked
// - Accuracy alarm only in master mode, at limit
// - Own failure: hand over unless duplicate out
// - All references failed: holdover, hand to good duplicate
// - Unframed: no pulses for 8 ms means loss
// - Loss alarm holds until 16 s without framing loss
// - Phase variance above 5 us rms: jitter alarm
// - Framed: drop sample after framing error or loss
package tref_pkg;
	localparam int NREF = 8;
	localparam int IDXW = 3;
	localparam int PRIOW = 3;
	localparam int PHW = 16;
	localparam int CLK_HZ = 25_000_000;
	// Times in their own units and derived cycle counts
	localparam int LOS_MS = 8;
	localparam int LOS_CYC = LOS_MS * (CLK_HZ / 1000);
	localparam int CLEAR_S = 16;
	localparam int CLEAR_CYC = CLEAR_S * CLK_HZ;
	localparam int RECOVER_S = 10;
	localparam int RECOVER_CYC = RECOVER_S * CLK_HZ;
	// Phase samples: one step is 8 ns
	localparam int PHASE_LSB_NS = 8;
	localparam int PA_LIMIT_US = 125;
	localparam int PA_LIMIT = PA_LIMIT_US * 1000 / PHASE_LSB_NS;
	localparam int JIT_RMS_US = 5;
	localparam int JIT_RMS = JIT_RMS_US * 1000 / PHASE_LSB_NS;
	localparam logic [33:0] JIT_VAR_LIM = 34'(JIT_RMS * JIT_RMS);
	localparam int VAR_SHIFT = 4;
	// Frequency offsets in units of 0.01 ppm
	localparam int FREQ_LIMIT_PPM = 9;
	localparam int FREQ_LIMIT = FREQ_LIMIT_PPM * 100;
	localparam int ACCURACY_LIMIT = 1600;
	localparam int CTRL_FULL = 32767;
	localparam int EOR_LIMIT = CTRL_FULL * 3 / 4;
	// Register byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_FRAMED = 8'h04;
	localparam logic [7:0] ADDR_SERVICE = 8'h08;
	localparam logic [7:0] ADDR_PRIO = 8'h0c;
	localparam logic [7:0] ADDR_STEP = 8'h10;
	localparam logic [7:0] ADDR_STATUS = 8'h14;
	localparam logic [7:0] ADDR_REFSTAT = 8'h18;
	localparam logic [7:0] ADDR_FOFAIL = 8'h1c;
	localparam int CTRL_MASTER_BIT = 0;
	localparam logic [15:0] STEP_RST = 16'h0100;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {ST_HOLD, ST_RECOVER, ST_LOCKED, ST_MASTER} sel_state_t;
endpackage

/* File: design/ref_health_monitor.sv */
module ref_health_monitor import tref_pkg::*; #(
	parameter int LOS_CYCLES = LOS_CYC,
	parameter int CLEAR_CYCLES = CLEAR_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Reference observations
	input wire logic pulse,
	input wire logic framed,
	input wire logic carrier_fail,
	input wire logic framing_lost_event,
	input wire logic frame_err,
	input wire logic sample_valid,
	input wire logic signed [PHW-1:0] sample,
	input wire logic step,
	// Health results
	output logic reference_loss_alarm,
	output logic jitter_alarm,
	output logic sample_clean
);
	logic [31:0] gap_ff, nxt_gap, quiet_ff, nxt_quiet, jq_ff, nxt_jq;
	logic loss_ff, nxt_loss, jit_ff, nxt_jit, dirty_ff, nxt_dirty;
	logic signed [PHW-1:0] prev_ff, nxt_prev;
	logic [33:0] var_ff, nxt_var, dev2;
	logic signed [PHW:0] dev;
	logic los, fail_now, bad_now;

	// Next health state
	always_comb begin
		nxt_gap = pulse ? 32'h0 : (gap_ff == 32'hffffffff ? gap_ff : gap_ff + 32'h1);
		los = !framed && gap_ff >= 32'(LOS_CYCLES);
		fail_now = framed ? carrier_fail : los;
		bad_now = fail_now | (framed & framing_lost_event);
		nxt_loss = loss_ff;
		nxt_quiet = quiet_ff;
		if (fail_now) begin
			nxt_loss = 1'b1;
			nxt_quiet = 32'h0;
		end else if (loss_ff) begin
			// Release only after a long clean stretch
			nxt_quiet = bad_now ? 32'h0 : quiet_ff + 32'h1;
			if (!bad_now && quiet_ff >= 32'(CLEAR_CYCLES - 1))
				nxt_loss = 1'b0;
		end
		dev = 17'(sample) - 17'(prev_ff);
		dev2 = step ? {34{1'b1}} : 34'(dev * dev);
		nxt_prev = sample_valid ? sample : prev_ff;
		nxt_var = var_ff;
		if (sample_valid || step)
			nxt_var = var_ff - (var_ff >> VAR_SHIFT) + (dev2 >> VAR_SHIFT);
		nxt_jit = jit_ff;
		nxt_jq = jq_ff;
		if (var_ff > JIT_VAR_LIM) begin
			nxt_jit = 1'b1;
			nxt_jq = 32'h0;
		end else if (jit_ff) begin
			nxt_jq = jq_ff + 32'h1;
			if (jq_ff >= 32'(CLEAR_CYCLES - 1))
				nxt_jit = 1'b0;
		end
		// Framing trouble since last sample, set wins
		nxt_dirty = (dirty_ff & ~sample_valid) | framing_lost_event | frame_err;
		sample_clean = !framed || !(dirty_ff | framing_lost_event | frame_err);
	end

	// Health registers
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			gap_ff <= 32'h0;
			quiet_ff <= 32'h0;
			jq_ff <= 32'h0;
			loss_ff <= 1'b0;
			jit_ff <= 1'b0;
			dirty_ff <= 1'b0;
			prev_ff <= '0;
			var_ff <= 34'h0;
		end else begin
			gap_ff <= nxt_gap;
			quiet_ff <= nxt_quiet;
			jq_ff <= nxt_jq;
			loss_ff <= nxt_loss;
			jit_ff <= nxt_jit;
			dirty_ff <= nxt_dirty;
			prev_ff <= nxt_prev;
			var_ff <= nxt_var;
		end
	end

	assign reference_loss_alarm = loss_ff;
	assign jitter_alarm = jit_ff;
endmodule // ref_health_monitor

/* File: verification/tref_assertions.sv */
module tref_assertions import tref_pkg::*; #(
	parameter int RECOVER_CYCLES = RECOVER_CYC
) (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic ARST_N,
	// Loop and duplicate inputs
	input wire logic FREQ_OFFSET_VALID,
	input wire logic signed [15:0] FREQ_OFFSET,
	input wire logic signed [15:0] LOOP_CTRL,
	input wire logic signed [15:0] LOOP_PHASE,
	input wire logic SELF_FAULT,
	input wire logic MATE_IN_SERVICE,
	input wire logic MATE_REF_GOOD,
	// Selection, loop feed and alarms
	input wire logic HOLDOVER,
	input wire logic LOOP_SAMPLE_VALID,
	input wire logic signed [PHW-1:0] LOOP_SAMPLE,
	input wire logic FREQ_OFFSET_ALARM,
	input wire logic CONTROL_RANGE_LIMIT_ALARM,
	input wire logic PHASE_ALIGN_ALARM,
	input wire logic FREQ_ACCURACY_ALARM,
	input wire logic SYNC_ACTIVE,
	input wire logic SYNC_OUT_OF_SERVICE
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [31:0] hold_ff;
	logic [31:0] nxt_hold;
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!ARST_N);
	// Length of the current holdover spell
	always_comb nxt_hold = HOLDOVER ? hold_ff + 32'h1 : 32'h0;
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) hold_ff <= '0;
		else hold_ff <= nxt_hold;
	end
	AST_HOLD_MIN: assert property (
		$fell(HOLDOVER) |-> hold_ff >= RECOVER_CYCLES) else $error("short holdover");
	AST_EOR_SET: assert property (
		!HOLDOVER && LOOP_CTRL > EOR_LIMIT |=> CONTROL_RANGE_LIMIT_ALARM)
		else $error("range alarm missing");
	AST_EOR_CLR: assert property (
		LOOP_CTRL >= 0 && LOOP_CTRL <= EOR_LIMIT |=> !CONTROL_RANGE_LIMIT_ALARM)
		else $error("range alarm false");
	AST_PHASE: assert property (
		!HOLDOVER && LOOP_PHASE > PA_LIMIT |=> PHASE_ALIGN_ALARM)
		else $error("phase alarm missing");
	AST_ACCURACY: assert property (
		FREQ_ACCURACY_ALARM |-> $past(HOLDOVER)) else $error("accuracy alarm");
	AST_OFFSET: assert property (
		!HOLDOVER && FREQ_OFFSET_VALID && FREQ_OFFSET > FREQ_LIMIT
		|-> ##[1:2] FREQ_OFFSET_ALARM) else $error("offset alarm missing");
	AST_LOOP_FEED: assert property (
		$changed(LOOP_SAMPLE) |-> LOOP_SAMPLE_VALID) else $error("loop jump");
	AST_SWAP: assert property (
		SYNC_ACTIVE && SELF_FAULT && MATE_IN_SERVICE
		|=> !SYNC_ACTIVE && SYNC_OUT_OF_SERVICE) else $error("no swap");
	AST_STAY: assert property (
		SYNC_ACTIVE && SELF_FAULT && !MATE_IN_SERVICE |=> SYNC_ACTIVE)
		else $error("swap to idle mate");
	AST_HAND: assert property (
		SYNC_ACTIVE && HOLDOVER && MATE_IN_SERVICE && MATE_REF_GOOD
		|=> !SYNC_ACTIVE) else $error("no hand-over");
endmodule // tref_assertions

/* File: verification/ref_source_model.sv */
module ref_source_model import tref_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Bench control
	input wire logic [NREF-1:0] alive,
	input wire logic jump,
	// Reference signals
	output logic [NREF-1:0] pulse,
	output logic [NREF-1:0] sample_valid,
	output logic [NREF*PHW-1:0] sample
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] cnt_ff;
	logic [15:0] ph;
	// Free-running time base
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) cnt_ff <= '0;
		else cnt_ff <= cnt_ff + 16'h1;
	end
	// Slow phase ramp, a jump adds a large step
	assign ph = jump ? cnt_ff + 16'h4000 : cnt_ff;
	// Dead inputs: no pulses, toggling pattern
	always_comb begin
		for (int i = 0; i < NREF; i++) begin
			pulse[i] = alive[i] && cnt_ff[1:0] == 2'h0;
			sample_valid[i] = alive[i] && cnt_ff[3:0] == 4'h0;
			sample[i*PHW +: PHW] = alive[i] ? ph : ~cnt_ff;
		end
	end
endmodule // ref_source_model

/* File: verification/testbench.sv */
module testbench import tref_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int clr_cyc = 50;
	// Design and model signals
	logic SYS_CLK, ARST_N, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
	logic ARVALID, ARREADY, RVALID, RREADY, FREQ_OFFSET_VALID, jump;
	logic [7:0] AWADDR, ARADDR;
	logic [31:0] WDATA, RDATA;
	logic [3:0] WSTRB;
	logic [1:0] BRESP, RRESP;
	logic [NREF-1:0] REF_PULSE, REF_CARRIER_FAIL, FRAMING_LOST_EVENT, alive;
	logic [NREF-1:0] REF_FRAME_ERR, REF_BER_MINOR, REF_BER_MAJOR;
	logic [NREF-1:0] REF_SAMPLE_VALID;
	logic [NREF*PHW-1:0] REF_SAMPLE;
	logic signed [15:0] FREQ_OFFSET, LOOP_CTRL, LOOP_PHASE, OUT_FREQ_ERR;
	logic signed [PHW-1:0] LOOP_SAMPLE;
	logic SELF_FAULT, MATE_IN_SERVICE, MATE_REF_GOOD, HOLDOVER;
	logic [IDXW-1:0] ACTIVE_REF;
	logic LOOP_SAMPLE_VALID, FREQ_OFFSET_ALARM, CONTROL_RANGE_LIMIT_ALARM;
	logic PHASE_ALIGN_ALARM, FREQ_ACCURACY_ALARM, SYNC_ACTIVE;
	logic SYNC_OUT_OF_SERVICE;
	int miscompares = 0;
	int checked = 0;
	timing_reference_selector #(.LOS_CYCLES(20), .CLEAR_CYCLES(clr_cyc),
		.RECOVER_CYCLES(10)) u_timing_reference_selector (.*);
	ref_source_model u_ref_source_model (.clk(SYS_CLK), .arst_n(ARST_N),
		.alive(alive), .jump(jump), .pulse(REF_PULSE),
		.sample_valid(REF_SAMPLE_VALID), .sample(REF_SAMPLE));
	// Clock
	initial begin
		SYS_CLK = 1'b0;
		forever #20 SYS_CLK = ~SYS_CLK;
	end
	task automatic final_report();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge SYS_CLK);
	endtask
	// Bus write, address and data offered together
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] e);
		AWADDR <= a;
		WDATA <= d;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		do begin
			tick(1);
			if (AWREADY) AWVALID <= 1'b0;
			if (WREADY) WVALID <= 1'b0;
		end while (!BVALID);
		chk(32'(BRESP), 32'(e));
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er);
		ARADDR <= a;
		ARVALID <= 1'b1;
		do begin
			tick(1);
			if (ARREADY) ARVALID <= 1'b0;
		end while (!RVALID);
		chk(RDATA, e);
		chk(32'(RRESP), 32'(er));
	endtask
	// Bounded wait for lock to one reference
	task automatic wait_ref(input logic [2:0] r);
		int n;
		n = 0;
		while (!(HOLDOVER === 1'b0 && ACTIVE_REF === r) && n < 300) begin
			tick(1);
			n++;
		end
		chk(32'({HOLDOVER, ACTIVE_REF}), 32'(r));
	endtask
	task automatic ofs(input logic [15:0] v);
		FREQ_OFFSET <= v;
		FREQ_OFFSET_VALID <= 1'b1;
		tick(1);
		FREQ_OFFSET_VALID <= 1'b0;
		tick(3);
	endtask
	task automatic lim(input logic [15:0] c, input logic [15:0] p,
		input logic [1:0] e);
		LOOP_CTRL <= c;
		LOOP_PHASE <= p;
		tick(3);
		chk(32'({CONTROL_RANGE_LIMIT_ALARM, PHASE_ALIGN_ALARM}), 32'(e));
	endtask
	// Reset values, read-back, unmapped place
	task automatic t_regs();
		rd(ADDR_STEP, 32'h100, RESP_OKAY);
		rd(ADDR_STATUS, 32'h18, RESP_OKAY);
		wr(ADDR_PRIO, 32'he9, RESP_OKAY);
		rd(ADDR_PRIO, 32'he9, RESP_OKAY);
		wr(8'h40, 32'h1, RESP_SLVERR);
		rd(8'h40, 32'h0, RESP_SLVERR);
	endtask
	// Ranking by class, priority and service
	task automatic t_select();
		wr(ADDR_SERVICE, 32'h7, RESP_OKAY);
		wait_ref(3'h1);
		REF_BER_MINOR <= 8'h02;
		wait_ref(3'h2);
		REF_BER_MAJOR <= 8'h04;
		wait_ref(3'h0);
		REF_BER_MINOR <= 8'h00;
		REF_BER_MAJOR <= 8'h00;
		wait_ref(3'h1);
		wr(ADDR_SERVICE, 32'h5, RESP_OKAY);
		wait_ref(3'h2);
	endtask
	// Loss of pulses and clearing hysteresis
	task automatic t_loss();
		alive <= 8'h03;
		tick(12);
		chk(32'(ACTIVE_REF), 32'h2);
		wait_ref(3'h0);
		alive <= 8'h07;
		tick(clr_cyc / 2);
		chk(32'(ACTIVE_REF), 32'h0);
		wait_ref(3'h2);
	endtask
	// Offset limit, failure flag and its clearing
	task automatic t_offset();
		ofs(16'h384);
		chk(32'(FREQ_OFFSET_ALARM), 32'h0);
		ofs(16'h385);
		chk(32'(FREQ_OFFSET_ALARM), 32'h1);
		wait_ref(3'h0);
		rd(ADDR_FOFAIL, 32'h4, RESP_OKAY);
		wr(ADDR_FOFAIL, 32'h4, RESP_OKAY);
		rd(ADDR_FOFAIL, 32'h0, RESP_OKAY);
		wait_ref(3'h2);
	endtask
	// Loop alarms at and past their limits
	task automatic t_alarms();
		lim(16'h5fff, 16'h3d09, 2'h0);
		lim(16'h6000, 16'h3d0a, 2'h3);
		lim(16'h0, 16'h0, 2'h0);
	endtask
	// A phase step never reaches the loop
	task automatic t_step();
		logic seen;
		int n;
		logic [15:0] ls;
		wr(ADDR_FRAMED, 32'h4, RESP_OKAY);
		n = 0;
		while (LOOP_SAMPLE_VALID !== 1'b1 && n < 40) begin
			tick(1);
			n++;
		end
		chk(32'(LOOP_SAMPLE_VALID), 32'h1);
		// Framing error: next sample dropped, the one after passes
		ls = LOOP_SAMPLE;
		REF_FRAME_ERR <= 8'h04;
		tick(1);
		REF_FRAME_ERR <= 8'h00;
		tick(15);
		chk(32'(LOOP_SAMPLE_VALID), 32'h0);
		tick(16);
		ls = ls + 16'h10;
		chk(32'({LOOP_SAMPLE_VALID, LOOP_SAMPLE}), 32'({1'b1, ls}));
		jump <= 1'b1;
		seen = 1'b0;
		for (int i = 0; i < 20; i++) begin
			tick(1);
			if (i == 15) jump <= 1'b0;
			seen = seen | LOOP_SAMPLE_VALID;
		end
		chk(32'(seen), 32'h0);
		rd(ADDR_REFSTAT, 32'h7f8, RESP_OKAY);
	endtask
	// Accuracy alarm in master mode only
	task automatic t_master();
		OUT_FREQ_ERR <= 16'h640;
		tick(3);
		chk(32'(FREQ_ACCURACY_ALARM), 32'h0);
		wr(ADDR_CTRL, 32'h1, RESP_OKAY);
		tick(3);
		chk(32'({FREQ_ACCURACY_ALARM, HOLDOVER}), 32'h3);
		wr(ADDR_CTRL, 32'h0, RESP_OKAY);
		tick(3);
		chk(32'(FREQ_ACCURACY_ALARM), 32'h0);
	endtask
	// Duplicate synchronizer hand-over
	task automatic t_dup();
		wr(ADDR_SERVICE, 32'h0, RESP_OKAY);
		MATE_IN_SERVICE <= 1'b1;
		MATE_REF_GOOD <= 1'b1;
		tick(3);
		chk(32'(SYNC_ACTIVE), 32'h0);
		MATE_IN_SERVICE <= 1'b0;
		tick(3);
		chk(32'(SYNC_ACTIVE), 32'h1);
		SELF_FAULT <= 1'b1;
		tick(3);
		chk(32'({SYNC_ACTIVE, SYNC_OUT_OF_SERVICE}), 32'h2);
		MATE_IN_SERVICE <= 1'b1;
		tick(3);
		chk(32'({SYNC_ACTIVE, SYNC_OUT_OF_SERVICE}), 32'h1);
	endtask
	// Main sequence
	initial begin
		ARST_N = 1'b0;
		{AWVALID, WVALID, ARVALID, FREQ_OFFSET_VALID, jump} = '0;
		{SELF_FAULT, MATE_IN_SERVICE, MATE_REF_GOOD} = '0;
		{AWADDR, ARADDR, WDATA} = '0;
		{REF_CARRIER_FAIL, FRAMING_LOST_EVENT, REF_FRAME_ERR} = '0;
		{REF_BER_MINOR, REF_BER_MAJOR} = '0;
		{FREQ_OFFSET, LOOP_CTRL, LOOP_PHASE, OUT_FREQ_ERR} = '0;
		{BREADY, RREADY} = 2'h3;
		WSTRB = 4'hf;
		alive = 8'h07;
		tick(8);
		ARST_N <= 1'b1;
		tick(2);
		t_regs();
		t_select();
		t_loss();
		t_offset();
		t_alarms();
		t_step();
		t_master();
		t_dup();
		final_report();
	end
	// Watchdog
	initial begin
		#400000;
		miscompares++;
		final_report();
	end
endmodule // testbench
bind timing_reference_selector tref_assertions
	#(.RECOVER_CYCLES(RECOVER_CYCLES)) u_tref_assertions (.*);
